// >>> rtc_watchdog_supervisor_tb_top.sv
// Self-checking bench of the RTC supervisor core, driven through the host model.
// Assumes the core, its checker and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rtc_watchdog_supervisor_tb_top;
  // Bench inputs, the resolved pin and the core outputs.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  logic pfail = 1'b0;
  logic press = 1'b0;
  logic bat = 1'b0;
  logic wrap = 1'b0;
  logic pin, start, wr, rd, ok, pin_o, oe_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, chg;
  int errors = 0;
  int checks = 0;
  // The pin idles high on its pull-up; the core or the button pulls it low.
  assign pin = press ? 1'b0 : (oe_n ? 1'b1 : pin_o);
  // Short hold and debounce counts keep the run brief.
  rtcws_core #(.HOLD_TICKS(16'h0002), .DEB_TICKS(16'h0001), .OSC_TICKS(16'h0003))
    rtcws_core_inst (.CLK(clk), .RST_N(rst_n), .OSC_4096(osc), .POWER_FAIL(pfail),
    .ON_BATTERY(bat), .BUS_START(start), .PTR_WRAP(wrap), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACCESS_OK(ok),
    .RESET_OUT_N_I(pin), .RESET_OUT_N_O(pin_o), .RESET_OUT_N_OE_N(oe_n), .CHARGER_CONFIG(chg));
  rtcws_host_model rtcws_host_model_inst (.clk(clk), .rdata(rdata), .start(start),
    .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));
  // A 10 ns clock; the base toggles on falling edges, so one tick is near 164 cycles.
  initial forever #5 clk = ~clk;
  initial forever #20 osc = ~osc;
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Register access shorthands.
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    rtcws_host_model_inst.write_reg(a, d);
  endtask : w
  task automatic r(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rtcws_host_model_inst.read_reg(a, d);
    check($sformatf("reg %h", a), exp, d);
  endtask : r
  // Waits for the pin enable to reach a level; a hang ends the run as a mismatch.
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (oe_n !== lvl && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000)
    begin
      errors++;
      $display("wrong value oe_n expected %b seen %b", lvl, oe_n);
      finish_test();
    end
  endtask : wait_oe
  // Sets a time just before midnight and checks the calendar after it.
  // The snapshot comes from a bus start or, when use_wrap is set, from a pointer wrap.
  task automatic t_midnight(input logic [31:0] bef, input logic [31:0] aft,
                            input logic use_wrap);
    w(4'h7, bef[31:24]);
    w(4'h6, bef[23:16]);
    w(4'h5, bef[15:8]);
    w(4'h3, bef[7:0]);
    w(4'h4, 8'h07);
    w(4'h2, 8'h59);
    w(4'h1, 8'h59);
    w(4'h0, 8'h97);
    repeat (700) @(negedge clk);
    if (use_wrap)
    begin
      @(negedge clk);
      wrap = 1'b1;
      @(negedge clk);
      wrap = 1'b0;
    end
    else
      rtcws_host_model_inst.start_pulse();
    r(4'h7, aft[31:24]);
    r(4'h6, aft[23:16]);
    r(4'h5, aft[15:8]);
    r(4'h3, aft[7:0]);
    r(4'h4, 8'h01);
  endtask : t_midnight
  // Serviced watchdog never fires; left alone it flags without touching the pin.
  task automatic t_wdog();
    logic [7:0] d;
    w(4'hC, 8'h00);
    w(4'h8, 8'h04);
    w(4'h9, 8'h00);
    repeat (400) @(negedge clk);
    r(4'h8, 8'h04);
    w(4'hC, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      repeat (250) @(negedge clk);
      rtcws_host_model_inst.read_reg(4'h8, d);
      check("count", 8'h01, {7'h0, d inside {8'h02, 8'h03}});
    end
    r(4'hB, 8'h00);
    repeat (1000) @(negedge clk);
    r(4'hB, 8'h40);
    check("oe_n", 8'h01, {7'h0, oe_n});
    w(4'hB, 8'h40);
    r(4'hB, 8'h40);
    w(4'hB, 8'h00);
    // The spent counter stands at zero and must not raise the flag again.
    repeat (400) @(negedge clk);
    r(4'hB, 8'h00);
  endtask : t_wdog
  // Expiry with the reset bit pulses the pin and refuses a write meanwhile.
  task automatic t_wrst();
    logic [7:0] d;
    int n;
    w(4'hC, 8'h00);
    w(4'h8, 8'h02);
    w(4'hC, 8'h03);
    wait_oe(1'b0, n);
    check("access", 8'h00, {7'h0, ok});
    w(4'hC, 8'h00);
    rtcws_host_model_inst.read_reg(4'h8, d);
    wait_oe(1'b1, n);
    repeat (4) @(negedge clk);
    r(4'hC, 8'h03);
    r(4'hB, 8'h40);
    w(4'hC, 8'h00);
    w(4'hB, 8'h00);
  endtask : t_wrst
  // Press, debounce, long hold, then a release pulse.
  task automatic t_button();
    int n;
    press = 1'b1;
    wait_oe(1'b0, n);
    check("press delay", 8'h01, {7'h0, n < 8});
    wait_oe(1'b1, n);
    repeat (100) @(negedge clk);
    check("held", 8'h01, {7'h0, oe_n});
    press = 1'b0;
    wait_oe(1'b0, n);
    check("release delay", 8'h01, {7'h0, n < 8});
    wait_oe(1'b1, n);
    repeat (4) @(negedge clk);
  endtask : t_button
  // Supply failure, plain and with the oscillator-off bit, which lengthens the hold.
  task automatic t_power();
    int n0;
    int n1;
    pfail = 1'b1;
    repeat (20) @(negedge clk);
    check("pf pin", 8'h00, {7'h0, oe_n});
    pfail = 1'b0;
    wait_oe(1'b1, n0);
    check("pf hold", 8'h01, {7'h0, n0 > 300});
    repeat (4) @(negedge clk);
    w(4'hC, 8'h80);
    pfail = 1'b1;
    repeat (20) @(negedge clk);
    pfail = 1'b0;
    wait_oe(1'b1, n1);
    check("osc hold", 8'h01, {7'h0, n1 > n0 + 300});
    repeat (4) @(negedge clk);
    r(4'hC, 8'h80);
    // On battery with the stop bit set the crystal halts, which raises the stop flag.
    bat = 1'b1;
    repeat (20) @(negedge clk);
    bat = 1'b0;
    repeat (4) @(negedge clk);
    r(4'hB, 8'h80);
    w(4'hB, 8'h00);
    r(4'hB, 8'h00);
  endtask : t_power
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // Main sequence after a 12-cycle reset.
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    r(4'hB, 8'h80);
    r(4'hC, 8'h00);
    w(4'hB, 8'hC0);
    r(4'hB, 8'h80);
    w(4'hB, 8'h00);
    r(4'hB, 8'h00);
    w(4'hA, 8'hA5);
    check("charger", 8'hA5, chg);
    r(4'hA, 8'hA5);
    t_midnight(32'h0402_2971, 32'h0403_0152, 1'b0);
    t_midnight(32'h9912_3123, 32'h0001_0100, 1'b1);
    t_wdog();
    t_wrst();
    t_button();
    t_power();
    finish_test();
  end
  // Cuts a hang short.
  initial
  begin
    #900000;
    errors++;
    finish_test();
  end
endmodule : rtc_watchdog_supervisor_tb_top
`default_nettype wire

// >>> rtcws_core.sv
// Timekeeping, watchdog and reset supervisor core of a serial RTC.
// Assumes a serial protocol engine on CLK presents byte accesses and start/wrap pulses.
//
// How it works
// - Time registers hold and count in BCD.
// - Date wraps per month length, leap years.
// - Day of week cycles 01 to 07.
// - Hours bit 6 selects 12-hour mode.
// - Hours bit 5 is PM or tens.
// - Watchdog write loads counter and seed.
// - Watchdog read latches count, reloads seed.
// - Enabled nonzero counter decrements each hundredth.
// - Zero written while enabled stays stopped.
// - Disabled watchdog is plain sixteen-bit storage.
// - Expiry may pulse reset and block access.
// - Without reset bit, expiry only flags.
// - Any watchdog access reloads the countdown.
// - Power fail blocks access, holds reset.
// - Oscillator-off bit extends the hold time.
// - No access while reset pin low.
// - Falling pin edge starts debounce drive.
// - Release after debounce gives hold pulse.
// - Oscillator stop flag sticky, write zero.
// - Watchdog alarm flag sticky, write zero.
// - Oscillator stops only on battery.
// - Start or wrap snapshots time.
// - Hundredths tick divides 4096 Hz.
`include "rtcws_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcws_core #(
  parameter logic [15:0] HOLD_TICKS = `RTCWS_HOLD_TICKS,
  parameter logic [15:0] DEB_TICKS = `RTCWS_DEB_TICKS,
  parameter logic [15:0] OSC_TICKS = `RTCWS_OSC_TICKS
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Analog and crystal side, asynchronous.
  input wire logic OSC_4096,
  input wire logic POWER_FAIL,
  input wire logic ON_BATTERY,
  // Register port from the serial engine.
  input wire logic BUS_START,
  input wire logic PTR_WRAP,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_ACCESS_OK,
  // Open-drain reset pin.
  input wire logic RESET_OUT_N_I,
  output logic RESET_OUT_N_O,
  output logic RESET_OUT_N_OE_N,
  // Trickle charger setting for the analog block.
  output logic [7:0] CHARGER_CONFIG
);

  logic [1:0] rst_sy;
  logic rst_n;
  rtcws_pkg::rtcws_state_s s;
  rtcws_pkg::rtcws_state_s next_s;

  // BCD increment with wrap; returns carry and next value.
  function automatic logic [8:0] bcd_wrap(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] low);
    logic [7:0] r;
    if (v == top)
    begin
      return {1'b1, low};
    end
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    return {1'b0, r};
  endfunction : bcd_wrap

  // Hours step in either format; carry marks midnight.
  function automatic logic [8:0] hour_step(input logic [7:0] h);
    logic [7:0] r;
    logic c;
    r = h;
    c = 1'b0;
    if (h[`RTCWS_HR_12H])
    begin
      if (h[4:0] == 5'h12)
        r[4:0] = 5'h01;
      else if (h[4:0] == 5'h11)
      begin
        r[4:0] = 5'h12;
        r[`RTCWS_HR_PM] = ~h[`RTCWS_HR_PM];
        c = h[`RTCWS_HR_PM];
      end
      else
        r[4:0] = 5'(bcd_wrap({3'h0, h[4:0]}, `RTCWS_TOP_HUND, `RTCWS_LOW_ZERO));
    end
    else if (h[5:0] == 6'h23)
    begin
      r[5:0] = 6'h00;
      c = 1'b1;
    end
    else
      r[5:0] = 6'(bcd_wrap({2'h0, h[5:0]}, `RTCWS_TOP_HUND, `RTCWS_LOW_ZERO));
    return {c, r};
  endfunction : hour_step

  // Last date of a month, leap years judged from the BCD year up to 2099.
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_end

  // Four-digit BCD decrement.
  function automatic logic [15:0] bcd_dec16(input logic [15:0] v);
    logic [15:0] r;
    logic b;
    r = v;
    b = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (b)
      begin
        if (r[i*4 +: 4] == 4'h0)
          r[i*4 +: 4] = 4'h9;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec16

  // Write mask of each time register; reserved bits stay zero.
  function automatic logic [7:0] time_mask(input logic [3:0] a);
    unique case (a)
      `RTCWS_A_SEC, `RTCWS_A_MIN, `RTCWS_A_HOUR: return `RTCWS_M_SEC;
      `RTCWS_A_DOW: return `RTCWS_M_DOW;
      `RTCWS_A_DATE: return `RTCWS_M_DATE;
      `RTCWS_A_MONTH: return `RTCWS_M_MONTH;
      default: return `RTCWS_M_FULL;
    endcase
  endfunction : time_mask

  // Reset release through two flip-flops.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sy <= 2'h0;
    else
      rst_sy <= {rst_sy[0], 1'b1};
  end
  assign rst_n = rst_sy[1];

  logic tick4k;
  logic tick100;
  logic pf;
  logic pin_hi;
  logic blocked;
  logic acc_wr;
  logic acc_rd;
  logic wd_acc;
  logic wd_exp;
  logic [15:0] hold_len;
  logic [15:0] wd_dec;
  logic [8:0] st;

  // Whole next state.
  always_comb
  begin
    next_s = s;
    st = 9'h000;
    // The second stage of each synchroniser feeds logic; tick and pin edges also use the third.
    next_s.tick_sy = {s.tick_sy[1:0], OSC_4096};
    next_s.pf_sy = {s.pf_sy[0], POWER_FAIL};
    next_s.bat_sy = {s.bat_sy[0], ON_BATTERY};
    next_s.pin_sy = {s.pin_sy[1:0], RESET_OUT_N_I};
    tick4k = s.tick_sy[1] & ~s.tick_sy[2];
    pf = s.pf_sy[1];
    pin_hi = s.pin_sy[1];

    // 100 Hz tick: 41 base periods 24 times, then 40 once.
    tick100 = 1'b0;
    if (tick4k)
    begin
      if (s.div == ((s.phase == `RTCWS_DIV_LAST) ? `RTCWS_DIV_SHORT : `RTCWS_DIV_LONG))
      begin
        next_s.div = 6'h00;
        next_s.phase = (s.phase == `RTCWS_DIV_LAST) ? 5'h00 : s.phase + 5'h01;
        tick100 = 1'b1;
      end
      else
        next_s.div = s.div + 6'h01;
    end

    // The crystal only stops on battery with the stop bit set.
    next_s.osc_run = ~(s.osc_off_on_battery & s.bat_sy[1]);
    if (s.osc_run && !next_s.osc_run)
      next_s.osc_stop_flag = 1'b1;

    // Access is refused while the supervisor or the pin says reset.
    blocked = (s.sup != rtcws_pkg::SV_IDLE) | ~pin_hi | pf;
    acc_wr = REG_WR & ~blocked;
    acc_rd = REG_RD & ~blocked;
    wd_acc = (acc_wr | acc_rd) & (REG_ADDR == `RTCWS_A_WDL || REG_ADDR == `RTCWS_A_WDH);

    // Calendar chain, all in BCD.
    if (tick100 && s.osc_run)
    begin
      st = bcd_wrap(s.tm[0], `RTCWS_TOP_HUND, `RTCWS_LOW_ZERO);
      next_s.tm[0] = st[7:0];
      if (st[8])
      begin
        st = bcd_wrap(s.tm[1], `RTCWS_TOP_SEC, `RTCWS_LOW_ZERO);
        next_s.tm[1] = st[7:0];
      end
      if (st[8])
      begin
        st = bcd_wrap(s.tm[2], `RTCWS_TOP_SEC, `RTCWS_LOW_ZERO);
        next_s.tm[2] = st[7:0];
      end
      if (st[8])
      begin
        st = hour_step(s.tm[3]);
        next_s.tm[3] = st[7:0];
      end
      if (st[8])
      begin
        next_s.tm[4][2:0] = 3'(bcd_wrap({5'h00, s.tm[4][2:0]}, `RTCWS_TOP_DOW,
                                        `RTCWS_LOW_ONE));
        st = bcd_wrap(s.tm[5], month_end(s.tm[6], s.tm[7]), `RTCWS_LOW_ONE);
        next_s.tm[5] = st[7:0];
      end
      if (st[8])
      begin
        st = bcd_wrap({3'h0, s.tm[6][4:0]}, `RTCWS_TOP_MONTH, `RTCWS_LOW_ONE);
        next_s.tm[6][4:0] = st[4:0];
      end
      if (st[8])
        next_s.tm[7] = 8'(bcd_wrap(s.tm[7], `RTCWS_TOP_YEAR, `RTCWS_LOW_ZERO));
    end

    // Snapshot for reads, taken from the time before this cycle's step.
    if (BUS_START || PTR_WRAP)
      next_s.shd = s.tm;

    // Watchdog countdown; a zero count is stopped.
    wd_dec = bcd_dec16(s.wcnt);
    wd_exp = 1'b0;
    if (tick100 && s.wdog_enable && s.wcnt != 16'h0000 && !wd_acc)
    begin
      next_s.wcnt = wd_dec;
      wd_exp = (wd_dec == 16'h0000);
    end

    // Register reads: the answer byte is latched here.
    if (acc_rd)
    begin
      unique case (REG_ADDR)
        `RTCWS_A_HUND, `RTCWS_A_SEC, `RTCWS_A_MIN, `RTCWS_A_HOUR,
        `RTCWS_A_DOW, `RTCWS_A_DATE, `RTCWS_A_MONTH, `RTCWS_A_YEAR:
          next_s.rdata = s.shd[REG_ADDR[2:0]];
        `RTCWS_A_WDL: next_s.rdata = s.wcnt[7:0];
        `RTCWS_A_WDH: next_s.rdata = s.wcnt[15:8];
        `RTCWS_A_CHG: next_s.rdata = s.chg;
        `RTCWS_A_FLAG: next_s.rdata = {s.osc_stop_flag, s.wf, 6'h00};
        `RTCWS_A_CTRL: next_s.rdata = {s.osc_off_on_battery, 5'h00, s.wdog_enable, s.wdrst};
        default: next_s.rdata = `RTCWS_RST_BYTE;
      endcase
      if (wd_acc)
        next_s.wcnt = s.wseed;
    end

    // Register writes; a write to a time byte overrides its count step.
    if (acc_wr)
    begin
      unique case (REG_ADDR)
        `RTCWS_A_WDL:
        begin
          next_s.wseed[7:0] = REG_WDATA;
          next_s.wcnt = {s.wseed[15:8], REG_WDATA};
        end
        `RTCWS_A_WDH:
        begin
          next_s.wseed[15:8] = REG_WDATA;
          next_s.wcnt = {REG_WDATA, s.wseed[7:0]};
        end
        `RTCWS_A_CHG: next_s.chg = REG_WDATA;
        `RTCWS_A_FLAG:
        begin
          next_s.osc_stop_flag = s.osc_stop_flag & REG_WDATA[`RTCWS_FLAG_OSF];
          next_s.wf = s.wf & REG_WDATA[`RTCWS_FLAG_WF];
        end
        `RTCWS_A_CTRL:
        begin
          next_s.osc_off_on_battery = REG_WDATA[`RTCWS_CTRL_OSC_OFF_ON_BATTERY];
          next_s.wdog_enable = REG_WDATA[`RTCWS_CTRL_WDE];
          next_s.wdrst = REG_WDATA[`RTCWS_CTRL_WDRST];
        end
        default:
          if (!REG_ADDR[3])
            next_s.tm[REG_ADDR[2:0]] = REG_WDATA & time_mask(REG_ADDR);
      endcase
    end

    // Hardware sets come last so that a set wins over a clear.
    if (s.osc_run && !next_s.osc_run)
      next_s.osc_stop_flag = 1'b1;
    if (wd_exp)
      next_s.wf = 1'b1;

    // Reset pin supervisor; the hold grows by the start-up time when the crystal may stop.
    hold_len = HOLD_TICKS + (s.osc_off_on_battery ? OSC_TICKS : 16'h0000);
    unique case (s.sup)
      rtcws_pkg::SV_IDLE:
      begin
        if (pf || (wd_exp && s.wdrst))
        begin
          next_s.sup = rtcws_pkg::SV_HOLD;
          next_s.scnt = hold_len;
        end
        else if (s.pin_sy[2] && !pin_hi)
        begin
          next_s.sup = rtcws_pkg::SV_DEBOUNCE;
          next_s.scnt = DEB_TICKS;
        end
      end
      rtcws_pkg::SV_HOLD:
      begin
        if (pf)
          next_s.scnt = hold_len;
        else if (tick100)
        begin
          if (s.scnt == 16'h0000)
            next_s.sup = rtcws_pkg::SV_IDLE;
          else
            next_s.scnt = s.scnt - 16'h0001;
        end
      end
      rtcws_pkg::SV_DEBOUNCE:
      begin
        if (pf)
        begin
          next_s.sup = rtcws_pkg::SV_HOLD;
          next_s.scnt = hold_len;
        end
        else if (tick100)
        begin
          if (s.scnt == 16'h0000)
            next_s.sup = rtcws_pkg::SV_WAIT_REL;
          else
            next_s.scnt = s.scnt - 16'h0001;
        end
      end
      rtcws_pkg::SV_WAIT_REL:
      begin
        // The pin is released here, so a high level means the button let go.
        if (pf || pin_hi)
        begin
          next_s.sup = rtcws_pkg::SV_HOLD;
          next_s.scnt = hold_len;
        end
      end
    endcase
  end

  // State register; power-up values stand in for first application of power.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.tm <= `RTCWS_RST_TIME;
      s.shd <= `RTCWS_RST_TIME;
      s.wcnt <= `RTCWS_RST_WD;
      s.wseed <= `RTCWS_RST_WD;
      s.osc_stop_flag <= 1'b1;
      s.wdrst <= 1'b0;
      s.osc_off_on_battery <= 1'b0;
      s.osc_run <= 1'b1;
      s.pin_sy <= 3'h7;
      s.sup <= rtcws_pkg::SV_IDLE;
    end
    else
      s <= next_s;
  end

  // Outputs; the pin is only ever pulled low.
  assign REG_RDATA = s.rdata;
  assign REG_ACCESS_OK = ~blocked;
  assign RESET_OUT_N_O = 1'b0;
  assign RESET_OUT_N_OE_N = ~(s.sup == rtcws_pkg::SV_HOLD || s.sup == rtcws_pkg::SV_DEBOUNCE);
  assign CHARGER_CONFIG = s.chg;

endmodule : rtcws_core
`default_nettype wire

// >>> rtcws_core_sva.sv
// Port checks of the RTC supervisor core.
// Assumes it is bound into rtcws_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rtcws_core_sva (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Watched ports.
  input wire logic POWER_FAIL,
  input wire logic REG_RD,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_ACCESS_OK,
  input wire logic RESET_OUT_N_I,
  input wire logic RESET_OUT_N_O,
  input wire logic RESET_OUT_N_OE_N
);
  // All checks sample on the core clock and sleep through reset.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // An accepted read, and a fall of an idle pin as a pushbutton makes it.
  sequence s_rd;
    REG_RD && REG_ACCESS_OK;
  endsequence
  sequence s_press;
    $fell(RESET_OUT_N_I) && $past(REG_ACCESS_OK) && !POWER_FAIL;
  endsequence
  // Synchroniser delays are why the supply checks wait a few cycles first.
  property p_od; RESET_OUT_N_O == 1'b0; endproperty
  property p_drv; !RESET_OUT_N_OE_N |-> !REG_ACCESS_OK; endproperty
  property p_pfa; POWER_FAIL [*4] |-> !REG_ACCESS_OK; endproperty
  property p_pfd; POWER_FAIL [*8] |-> !RESET_OUT_N_OE_N; endproperty
  property p_ref; REG_RD && !REG_ACCESS_OK |=> $stable(REG_RDATA); endproperty
  property p_bcd; s_rd ##0 (REG_ADDR < 4'h8 && REG_ADDR != 4'h4) |=> REG_RDATA[3:0] <= 4'h9;
  endproperty
  property p_dow; s_rd ##0 REG_ADDR == 4'h4 |=> REG_RDATA[2:0] != 3'h0; endproperty
  property p_btn; s_press |-> ##[1:6] !RESET_OUT_N_OE_N; endproperty
  a_od: assert property (p_od)
    else $error("reset pin driven high");
  a_drv: assert property (p_drv)
    else $error("access open while pin driven");
  a_pfa: assert property (p_pfa)
    else $error("access open in power fail");
  a_pfd: assert property (p_pfd)
    else $error("pin released in power fail");
  a_ref: assert property (p_ref)
    else $error("refused read changed data");
  a_bcd: assert property (p_bcd)
    else $error("time digit above nine");
  a_dow: assert property (p_dow)
    else $error("day of week zero");
  a_btn: assert property (p_btn)
    else $error("button press not driven");
endmodule : rtcws_core_sva
bind rtcws_core rtcws_core_sva rtcws_core_sva_inst (.CLK(CLK), .RST_N(RST_N),
  .POWER_FAIL(POWER_FAIL), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
  .REG_ACCESS_OK(REG_ACCESS_OK), .RESET_OUT_N_I(RESET_OUT_N_I),
  .RESET_OUT_N_O(RESET_OUT_N_O), .RESET_OUT_N_OE_N(RESET_OUT_N_OE_N));
`default_nettype wire

// >>> rtcws_host_model.sv
// Host model on the register port of the RTC supervisor core.
// Assumes the bench calls its tasks; requests change at falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module rtcws_host_model (
  // Clock and answer.
  input wire logic clk,
  input wire logic [7:0] rdata,
  // Requests.
  output logic start,
  output logic [3:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  // Idle lines at time zero.
  initial
  begin
    start = 1'b0;
    addr = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // One write over one rising edge; released data is inverted so it never looks valid.
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask : write_reg
  // One read; the byte is taken after the edge that accepted it.
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : read_reg
  // A bus start, which freezes the time snapshot.
  task automatic start_pulse();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : start_pulse
endmodule : rtcws_host_model
`default_nettype wire

// >>> rtcws_pkg.sv
// Types shared by the RTC supervisor core.
// Assumes rtcws_regs.svh is on the include path.
`default_nettype none
package rtcws_pkg;

  // Supervisor states of the reset pin.
  typedef enum logic [1:0] {SV_IDLE, SV_HOLD, SV_DEBOUNCE, SV_WAIT_REL} rtcws_sup_e;

  // Whole state of the core.
  typedef struct packed {
    logic [2:0] tick_sy;
    logic [1:0] pf_sy;
    logic [1:0] bat_sy;
    logic [2:0] pin_sy;
    logic [5:0] div;
    logic [4:0] phase;
    logic [7:0][7:0] tm;
    logic [7:0][7:0] shd;
    logic [15:0] wcnt;
    logic [15:0] wseed;
    logic [7:0] chg;
    logic osc_stop_flag;
    logic wf;
    logic osc_off_on_battery;
    logic wdog_enable;
    logic wdrst;
    logic osc_run;
    rtcws_sup_e sup;
    logic [15:0] scnt;
    logic [7:0] rdata;
  } rtcws_state_s;

endpackage : rtcws_pkg
`default_nettype wire

// >>> rtcws_regs.svh
// Register offsets, field positions, reset values and timing counts of the RTC supervisor.
// Assumes inclusion by the core module only.
`ifndef RTCWS_REGS_SVH
`define RTCWS_REGS_SVH

// Register offsets inside the timekeeping block.
`define RTCWS_A_HUND 4'h0
`define RTCWS_A_SEC 4'h1
`define RTCWS_A_MIN 4'h2
`define RTCWS_A_HOUR 4'h3
`define RTCWS_A_DOW 4'h4
`define RTCWS_A_DATE 4'h5
`define RTCWS_A_MONTH 4'h6
`define RTCWS_A_YEAR 4'h7
`define RTCWS_A_WDL 4'h8
`define RTCWS_A_WDH 4'h9
`define RTCWS_A_CHG 4'hA
`define RTCWS_A_FLAG 4'hB
`define RTCWS_A_CTRL 4'hC

// Field positions.
`define RTCWS_HR_12H 6
`define RTCWS_HR_PM 5
`define RTCWS_FLAG_OSF 7
`define RTCWS_FLAG_WF 6
`define RTCWS_CTRL_OSC_OFF_ON_BATTERY 7
`define RTCWS_CTRL_WDE 1
`define RTCWS_CTRL_WDRST 0

// Writable bits of the time registers.
`define RTCWS_M_SEC 8'h7F
`define RTCWS_M_DOW 8'h0F
`define RTCWS_M_DATE 8'h3F
`define RTCWS_M_MONTH 8'h3F
`define RTCWS_M_FULL 8'hFF

// BCD limits of the counters.
`define RTCWS_TOP_HUND 8'h99
`define RTCWS_TOP_SEC 8'h59
`define RTCWS_TOP_DOW 8'h07
`define RTCWS_TOP_MONTH 8'h12
`define RTCWS_TOP_YEAR 8'h99
`define RTCWS_LOW_ONE 8'h01
`define RTCWS_LOW_ZERO 8'h00

// Reset values: 01/01/00, day 01, 00:00:00.00.
`define RTCWS_RST_TIME 64'h0001_0101_0000_0000
`define RTCWS_RST_WD 16'h0000
`define RTCWS_RST_BYTE 8'h00

// Hundredths divider of the 4096 Hz base: 24 periods of 41, then one of 40.
`define RTCWS_DIV_LONG 6'h28
`define RTCWS_DIV_SHORT 6'h27
`define RTCWS_DIV_LAST 5'h18

// Supervisor times in 100 Hz ticks.
`define RTCWS_HOLD_TICKS 16'h0014
`define RTCWS_DEB_TICKS 16'h0003
`define RTCWS_OSC_TICKS 16'h0064

`endif
